// ===== fault_report_control.sv
/*
  Fault reporting control bank: mask, hold and recovery controls for the
  protection events, held event flags, fault report output and output
  disable. Registers are reached through a byte-wide request port from the
  device's serial control interface, which runs on CLK. Event inputs come
  from analog detectors and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_report_defs.svh"

// Functional notes
// - Mask bit 7 hides overtemp shutdown report
// - Bits 6,5 hide core supply low/high
// - Bit 4 hides clock fault report
// - Bit 2 hides both power supply faults
// - Bit 1 hides DC, bit 0 overcurrent
// - Hold enable bit 7 latches cycle-limit fault
// - Hold enable bit 6 latches cycle-limit warning
// - Hold enable bit 5 latches clock fault
// - Hold enable bit 4 latches overtemp shutdown
// - Hold enable bit 3 latches overtemp warning
// - Bit 2 hides overtemp warning report
// - Bit 1 hides cycle-limit warning report
// - Bit 0 hides cycle-limit fault report
// - Misc bit 7 holds clock detect state
// - Misc bit 4 enables overtemp self recovery
// - Writing one to clear bit clears faults
// - Clock/supply/overtemp faults hold outputs off
module fault_report_control
  import fault_report_pkg::*;
#(
  parameter int NUM_EVENTS = `NUM_EVENTS
) (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output var  logic [7:0] REG_RDATA,
  output var  logic       REG_ACK,
  input  wire logic [NUM_EVENTS-1:0] EVENT_IN,
  input  wire logic       CLOCK_DETECT_IN,
  output var  logic [NUM_EVENTS-1:0] EVENT_STATE,
  output var  logic       CLOCK_DETECT_STATE,
  output var  logic       FAULT_REPORT,
  output var  logic       OUTPUT_HIZ,
  output var  logic       CYCLE_LIMIT_ON,
  output var  logic       CYCLE_LIMIT_WARNING_ON,
  output var  logic       CYCLE_LIMIT_ERROR_ON,
  output var  logic       OVERTEMP_SELF_RECOVER,
  output var  logic       ANALOG_FAULT_CLEAR
);

  reg_req_t   req;
  logic [7:0] fault_report_mask;
  logic [7:0] report_latch_and_warning_mask;
  logic [7:0] misc_protection_control;
  logic [7:0] cycle_limit_control;
  logic [7:0] next_rdata;
  logic [NUM_EVENTS-1:0] live;
  logic [NUM_EVENTS-1:0] hold_en;
  logic [NUM_EVENTS-1:0] hide;
  logic [NUM_EVENTS-1:0] state;
  logic       clk_det_sync;
  logic       clk_det_held;
  logic       hold_clk_det;
  logic       next_clock_detect;
  logic       next_fault_report;
  logic       next_output_hiz;
  logic       clear_pulse;
  logic       wr_fault_report_mask;
  logic       wr_report_latch;
  logic       wr_misc_protection;
  logic       wr_cycle_limit;
  logic       wr_fault_clear;
  events_t    ev;

  // The mask and hold maps and the status struct are fixed at eleven events
  if (NUM_EVENTS != 11) begin : g_bad_events
    $error("fault_report_control NUM_EVENTS must be 11");
  end

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // One write strobe per register; unmapped addresses select nothing
  always_comb begin
    wr_fault_report_mask = 1'b0;
    wr_report_latch      = 1'b0;
    wr_misc_protection   = 1'b0;
    wr_cycle_limit       = 1'b0;
    wr_fault_clear       = 1'b0;
    if (req.wr) begin
      if (req.addr == `OFS_FAULT_REPORT_MASK) begin
        wr_fault_report_mask = 1'b1;
      end else if (req.addr == `OFS_REPORT_LATCH_MASK) begin
        wr_report_latch = 1'b1;
      end else if (req.addr == `OFS_MISC_PROTECTION) begin
        wr_misc_protection = 1'b1;
      end else if (req.addr == `OFS_CYCLE_LIMIT_CONTROL) begin
        wr_cycle_limit = 1'b1;
      end else if (req.addr == `OFS_FAULT_CLEAR_STROBE) begin
        wr_fault_clear = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fault_report_mask <= `RST_FAULT_REPORT_MASK;
    end else if (wr_fault_report_mask) begin
      fault_report_mask <= req.wdata & `WMASK_FAULT_REPORT_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      report_latch_and_warning_mask <= `RST_REPORT_LATCH_MASK;
    end else if (wr_report_latch) begin
      report_latch_and_warning_mask <= req.wdata;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      misc_protection_control <= `RST_MISC_PROTECTION;
    end else if (wr_misc_protection) begin
      misc_protection_control <= req.wdata;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cycle_limit_control <= `RST_CYCLE_LIMIT_CONTROL;
    end else if (wr_cycle_limit) begin
      cycle_limit_control <= req.wdata & `WMASK_CYCLE_LIMIT;
    end
  end

  // Strobe stands for one cycle after each write of one; never stored
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= wr_fault_clear && req.wdata[`BIT_ANALOG_FAULT_CLEAR];
    end
  end

  always_comb begin
    if (req.addr == `OFS_FAULT_REPORT_MASK) begin
      next_rdata = fault_report_mask;
    end else if (req.addr == `OFS_REPORT_LATCH_MASK) begin
      next_rdata = report_latch_and_warning_mask;
    end else if (req.addr == `OFS_MISC_PROTECTION) begin
      next_rdata = misc_protection_control;
    end else if (req.addr == `OFS_CYCLE_LIMIT_CONTROL) begin
      next_rdata = cycle_limit_control;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // Every request is acknowledged for one cycle after it is taken
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_ACK <= 1'b0;
    end else begin
      REG_ACK <= req.wr | req.rd;
    end
  end

  // Read data stands until the next read
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (req.rd) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Events and clock detect share one synchroniser
  pin_sync #(.WIDTH(NUM_EVENTS + 1)) u_sync (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .async_in ({CLOCK_DETECT_IN, EVENT_IN}),
    .sync_out ({clk_det_sync, live})
  );

  // Hold enables per event; supply and DC/overcurrent faults always hold
  always_comb begin
    hold_en     = '1;
    hold_en[0]  = report_latch_and_warning_mask[`BIT_HOLD_OVERTEMP_SHUTDOWN];
    hold_en[3]  = report_latch_and_warning_mask[`BIT_HOLD_CLOCK_ERROR];
    hold_en[8]  = report_latch_and_warning_mask[`BIT_HOLD_OVERTEMP_WARNING];
    hold_en[9]  = report_latch_and_warning_mask[`BIT_HOLD_CYCLE_LIMIT_WARNING];
    hold_en[10] = report_latch_and_warning_mask[`BIT_HOLD_CYCLE_LIMIT_ERROR];
  end

  // Bit 2 of the first mask covers both power stage limits
  always_comb begin
    hide     = '0;
    hide[0]  = fault_report_mask[`BIT_HIDE_OVERTEMP_SHUTDOWN];
    hide[1]  = fault_report_mask[`BIT_HIDE_CORE_SUPPLY_LOW];
    hide[2]  = fault_report_mask[`BIT_HIDE_CORE_SUPPLY_HIGH];
    hide[3]  = fault_report_mask[`BIT_HIDE_CLOCK_ERROR];
    hide[4]  = fault_report_mask[`BIT_HIDE_POWER_SUPPLY_LIMITS];
    hide[5]  = fault_report_mask[`BIT_HIDE_POWER_SUPPLY_LIMITS];
    hide[6]  = fault_report_mask[`BIT_HIDE_DC_OFFSET_ERROR];
    hide[7]  = fault_report_mask[`BIT_HIDE_OVERCURRENT_ERROR];
    hide[8]  = report_latch_and_warning_mask[`BIT_HIDE_OVERTEMP_WARNING];
    hide[9]  = report_latch_and_warning_mask[`BIT_HIDE_CYCLE_LIMIT_WARNING];
    hide[10] = report_latch_and_warning_mask[`BIT_HIDE_CYCLE_LIMIT_ERROR];
  end

  // One held flag per event, all released by the same clear strobe
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_hold
      event_hold u_hold (
        .clk     (CLK),
        .reset_n (RESET_N),
        .live    (live[gi]),
        .hold_en (hold_en[gi]),
        .clear   (clear_pulse),
        .state   (state[gi])
      );
    end
  endgenerate

  // Named view of the flags for the output-off decision
  assign ev = events_t'(state);

  // Clock detect status follows live detection unless holding is selected
  assign hold_clk_det = misc_protection_control[`BIT_HOLD_CLOCK_DETECT_STATE];

  // Nothing is kept while holding is off, so enabling it shows no stale detect
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_det_held <= 1'b0;
    end else if (clk_det_sync && hold_clk_det) begin
      clk_det_held <= 1'b1;
    end else if (clear_pulse || !hold_clk_det) begin
      clk_det_held <= 1'b0;
    end
  end

  always_comb begin
    next_clock_detect = clk_det_sync | (hold_clk_det & clk_det_held);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CLOCK_DETECT_STATE <= 1'b0;
    end else begin
      CLOCK_DETECT_STATE <= next_clock_detect;
    end
  end

  // Only the report output is gated by the masks
  always_comb begin
    next_fault_report = |(state & ~hide);
    next_output_hiz   = ev.clock_error | ev.core_supply_low | ev.core_supply_high
                        | ev.power_supply_low | ev.power_supply_high
                        | ev.overtemp_shutdown;
  end

  // Status keeps masked events
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EVENT_STATE <= '0;
    end else begin
      EVENT_STATE <= state;
    end
  end

  // Any unmasked flag raises the report
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAULT_REPORT <= 1'b0;
    end else begin
      FAULT_REPORT <= next_fault_report;
    end
  end

  // Outputs stay off while a clock, supply or shutdown flag stands
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OUTPUT_HIZ <= 1'b0;
    end else begin
      OUTPUT_HIZ <= next_output_hiz;
    end
  end

  // Cycle-limit function enable follows its register one edge later
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CYCLE_LIMIT_ON <= 1'b0;
    end else begin
      CYCLE_LIMIT_ON <= cycle_limit_control[`BIT_CYCLE_LIMIT_ON];
    end
  end

  // Warning enable of the cycle-limit function
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CYCLE_LIMIT_WARNING_ON <= 1'b0;
    end else begin
      CYCLE_LIMIT_WARNING_ON <= cycle_limit_control[`BIT_CYCLE_LIMIT_WARNING_ON];
    end
  end

  // Fault enable of the cycle-limit function
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CYCLE_LIMIT_ERROR_ON <= 1'b0;
    end else begin
      CYCLE_LIMIT_ERROR_ON <= cycle_limit_control[`BIT_CYCLE_LIMIT_ERROR_ON];
    end
  end

  // Self recovery after shutdown stays off until written
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OVERTEMP_SELF_RECOVER <= 1'b0;
    end else begin
      OVERTEMP_SELF_RECOVER <= misc_protection_control[`BIT_OVERTEMP_SELF_RECOVER];
    end
  end

  // Clear strobe to the analog faults stands for one cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ANALOG_FAULT_CLEAR <= 1'b0;
    end else begin
      ANALOG_FAULT_CLEAR <= clear_pulse;
    end
  end

endmodule : fault_report_control

`default_nettype wire

// ===== fault_report_defs.svh
/*
  Register offsets, field positions and reset values for the fault reporting
  control bank. Assumes inclusion by bare name from the package and modules.
*/
`ifndef FAULT_REPORT_DEFS_SVH
`define FAULT_REPORT_DEFS_SVH

`define OFS_FAULT_REPORT_MASK   8'h74
`define OFS_REPORT_LATCH_MASK   8'h75
`define OFS_MISC_PROTECTION     8'h76
`define OFS_CYCLE_LIMIT_CONTROL 8'h77
`define OFS_FAULT_CLEAR_STROBE  8'h78

`define RST_FAULT_REPORT_MASK   8'h00
`define RST_REPORT_LATCH_MASK   8'hF8
`define RST_MISC_PROTECTION     8'h00
`define RST_CYCLE_LIMIT_CONTROL 8'h00

`define WMASK_FAULT_REPORT_MASK 8'hF7
`define WMASK_CYCLE_LIMIT       8'hFF

`define BIT_HIDE_OVERTEMP_SHUTDOWN    7
`define BIT_HIDE_CORE_SUPPLY_LOW      6
`define BIT_HIDE_CORE_SUPPLY_HIGH     5
`define BIT_HIDE_CLOCK_ERROR          4
`define BIT_HIDE_POWER_SUPPLY_LIMITS  2
`define BIT_HIDE_DC_OFFSET_ERROR      1
`define BIT_HIDE_OVERCURRENT_ERROR    0

`define BIT_HOLD_CYCLE_LIMIT_ERROR    7
`define BIT_HOLD_CYCLE_LIMIT_WARNING  6
`define BIT_HOLD_CLOCK_ERROR          5
`define BIT_HOLD_OVERTEMP_SHUTDOWN    4
`define BIT_HOLD_OVERTEMP_WARNING     3
`define BIT_HIDE_OVERTEMP_WARNING     2
`define BIT_HIDE_CYCLE_LIMIT_WARNING  1
`define BIT_HIDE_CYCLE_LIMIT_ERROR    0

`define BIT_HOLD_CLOCK_DETECT_STATE   7
`define BIT_OVERTEMP_SELF_RECOVER     4

`define BIT_CYCLE_LIMIT_ON            2
`define BIT_CYCLE_LIMIT_WARNING_ON    1
`define BIT_CYCLE_LIMIT_ERROR_ON      0

`define BIT_ANALOG_FAULT_CLEAR        7

`define NUM_EVENTS 11

`endif

// ===== fault_report_pkg.sv
/*
  Types shared by the fault reporting control bank.
  Assumes fault_report_defs.svh is on the include path.
*/
`default_nettype none
`include "fault_report_defs.svh"

package fault_report_pkg;

  // Event vector order; bit index is the event number
  typedef struct packed {
    logic cycle_limit_error;
    logic cycle_limit_warning;
    logic overtemp_warning;
    logic overcurrent_error;
    logic dc_offset_error;
    logic power_supply_high;
    logic power_supply_low;
    logic clock_error;
    logic core_supply_high;
    logic core_supply_low;
    logic overtemp_shutdown;
  } events_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : fault_report_pkg

`default_nettype wire

// ===== event_hold.sv
/*
  One held fault flag: follows its live event, or holds it until cleared.
  Assumes event and clear are synchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module event_hold (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic live,
  input  wire logic hold_en,
  input  wire logic clear,
  output var  logic state
);

  logic held;

  // Set wins over a coincident clear; nothing is kept while holding is off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held <= 1'b0;
    end else if (live && hold_en) begin
      held <= 1'b1;
    end else if (clear || !hold_en) begin
      held <= 1'b0;
    end
  end

  assign state = hold_en ? (held | live) : live;

endmodule : event_hold

`default_nettype wire

// ===== pin_sync.sv
/*
  Three-stage synchroniser for asynchronous event inputs; a change is taken
  once stages two and three agree. Assumes a free running CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync WIDTH must be positive");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_out <= '0;
    end else begin
      sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== fault_report_asserts.sv
/*
  Port checker for fault_report_control, attached by bind.
  Assumes one clock domain, CLK, with RESET_N active low.
*/
`timescale 1ns/1ps
`default_nettype none

module fault_report_asserts (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [10:0] EVENT_STATE,
  input wire logic        FAULT_REPORT,
  input wire logic        OUTPUT_HIZ,
  input wire logic        CYCLE_LIMIT_ON,
  input wire logic        CYCLE_LIMIT_WARNING_ON,
  input wire logic        CYCLE_LIMIT_ERROR_ON,
  input wire logic        OVERTEMP_SELF_RECOVER,
  input wire logic        ANALOG_FAULT_CLEAR
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_clr;
    REG_WR && REG_ADDR == 8'h78 && REG_WDATA[7] |-> ##2 ANALOG_FAULT_CLEAR;
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse missing");
  property p_pulse;
    ANALOG_FAULT_CLEAR |-> $past(REG_WR, 2) && $past(REG_ADDR, 2) == 8'h78;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clear pulse without write");
  property p_rd78;
    REG_RD && REG_ADDR == 8'h78 |=> REG_RDATA == 8'h00;
  endproperty
  a_rd78: assert property (p_rd78) else $error("clear register not zero");
  property p_rd74;
    REG_RD && REG_ADDR == 8'h74 |=> !REG_RDATA[3];
  endproperty
  a_rd74: assert property (p_rd74) else $error("reserved bit set");
  property p_rep;
    FAULT_REPORT |-> EVENT_STATE != 11'h000;
  endproperty
  a_rep: assert property (p_rep) else $error("report without event");
  property p_hiz;
    OUTPUT_HIZ == (|EVENT_STATE[5:0]);
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not off");
  property p_held;
    ($past(EVENT_STATE) & ~EVENT_STATE & 11'h0F6) != 11'h000 |-> ANALOG_FAULT_CLEAR || $past(ANALOG_FAULT_CLEAR);
  endproperty
  a_held: assert property (p_held) else $error("held flag dropped");
  property p_cbc;
    logic [7:0] d;
    (REG_WR && REG_ADDR == 8'h77, d = REG_WDATA) |->
      ##2 {CYCLE_LIMIT_ON, CYCLE_LIMIT_WARNING_ON, CYCLE_LIMIT_ERROR_ON} == d[2:0];
  endproperty
  a_cbc: assert property (p_cbc) else $error("cycle limit enables wrong");
  property p_srec;
    logic [7:0] d;
    (REG_WR && REG_ADDR == 8'h76, d = REG_WDATA) |-> ##2 OVERTEMP_SELF_RECOVER == d[4];
  endproperty
  a_srec: assert property (p_srec) else $error("self recover wrong");
endmodule : fault_report_asserts

bind fault_report_control fault_report_asserts fault_report_asserts_i (
  .CLK(CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .EVENT_STATE(EVENT_STATE),
  .FAULT_REPORT(FAULT_REPORT), .OUTPUT_HIZ(OUTPUT_HIZ), .CYCLE_LIMIT_ON(CYCLE_LIMIT_ON),
  .CYCLE_LIMIT_WARNING_ON(CYCLE_LIMIT_WARNING_ON), .CYCLE_LIMIT_ERROR_ON(CYCLE_LIMIT_ERROR_ON),
  .OVERTEMP_SELF_RECOVER(OVERTEMP_SELF_RECOVER), .ANALOG_FAULT_CLEAR(ANALOG_FAULT_CLEAR));

`default_nettype wire

// ===== host_model.sv
/*
  Host side of the register request port.
  Assumes the bench calls xfer; requests start 1 ns after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model
  import fault_report_pkg::*;
(
  input  wire logic       clk,
  output var  reg_req_t   req,
  input  wire logic [7:0] rdata,
  input  wire logic       ack
);
  initial req = '0;

  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic ok);
    int i;
    @(posedge clk);
    #1;
    req = '{w, !w, a, d};
    @(posedge clk);
    #1;
    // Released lines show the inverse, not a stale value
    req = '{1'b0, 1'b0, ~a, ~d};
    for (i = 0; i < 4 && ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    ok = (ack === 1'b1);
    q = rdata;
  endtask : xfer
endmodule : host_model

`default_nettype wire

// ===== tb_fault_report_control.sv
/*
  Self-checking bench for fault_report_control.
  Assumes host_model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_fault_report_control;
  import fault_report_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  reg_req_t    req;
  logic [7:0]  rdata;
  logic        ack, cdi, cds, frep, hiz, srec;
  logic [2:0]  cl;
  logic [10:0] evi, evs;
  int          failures = 0;
  int          n_checks = 0;
  logic [15:0] mt [11] = '{16'h80F8, 16'h40F8, 16'h20F8, 16'h10F8, 16'h04F8, 16'h04F8,
                           16'h02F8, 16'h01F8, 16'h00FC, 16'h00FA, 16'h00F9};
  logic [23:0] wt [5] = '{24'h74FFF7, 24'h769090, 24'h788000, 24'h795500, 24'h770505};
  int          ho [5] = '{0, 3, 8, 9, 10};

  always #2.5 clk = ~clk;

  fault_report_control fault_report_control_i (
    .CLK(clk), .RESET_N(reset_n), .REG_WR(req.wr), .REG_RD(req.rd), .REG_ADDR(req.addr),
    .REG_WDATA(req.wdata), .REG_RDATA(rdata), .REG_ACK(ack), .EVENT_IN(evi),
    .CLOCK_DETECT_IN(cdi), .EVENT_STATE(evs), .CLOCK_DETECT_STATE(cds), .FAULT_REPORT(frep),
    .OUTPUT_HIZ(hiz), .CYCLE_LIMIT_ON(cl[2]), .CYCLE_LIMIT_WARNING_ON(cl[1]),
    .CYCLE_LIMIT_ERROR_ON(cl[0]), .OVERTEMP_SELF_RECOVER(srec), .ANALOG_FAULT_CLEAR());
  host_model host_model_i (.clk(clk), .req(req), .rdata(rdata), .ack(ack));

  task results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task xf(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    host_model_i.xfer(w, a, d, q, ok);
    chk(ok, 1'b1);
    if (!w)
      chk(q, e);
  endtask : xf

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  initial begin
    evi = '0;
    cdi = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    xf(0, 8'h74, 0, 8'h00);
    xf(0, 8'h75, 0, 8'hF8);
    xf(0, 8'h76, 0, 8'h00);
    xf(0, 8'h77, 0, 8'h00);
    $display("test reset done");
    foreach (wt[i]) begin
      xf(1, wt[i][23:16], wt[i][15:8], 0);
      xf(0, wt[i][23:16], 0, wt[i][7:0]);
    end
    chk({cl, srec}, 4'hB);
    xf(1, 8'h77, 8'h02, 0);
    cyc(1);
    chk({cl, srec}, 4'h5);
    $display("test access done");
    xf(1, 8'h76, 8'h00, 0);
    for (int i = 0; i < 11; i++) begin
      xf(1, 8'h74, mt[i][15:8], 0);
      xf(1, 8'h75, mt[i][7:0], 0);
      evi = 11'h001 << i;
      cyc(8);
      evi = 11'h000;
      cyc(8);
      chk(evs, 11'h001 << i);
      chk(frep, 1'b0);
      chk(hiz, i < 6);
      xf(1, 8'h74, 8'h00, 0);
      xf(1, 8'h75, 8'hF8, 0);
      cyc(2);
      chk(frep, 1'b1);
      xf(1, 8'h78, 8'h80, 0);
      cyc(3);
      chk(evs, 11'h000);
    end
    $display("test mask done");
    xf(1, 8'h75, 8'h00, 0);
    foreach (ho[i]) begin
      evi = 11'h001 << ho[i];
      cyc(8);
      chk(evs, 11'h001 << ho[i]);
      evi = 11'h000;
      cyc(8);
      chk(evs, 11'h000);
    end
    xf(1, 8'h75, 8'hF8, 0);
    cyc(2);
    chk(evs, 11'h000);
    $display("test hold done");
    cdi = 1'b1;
    cyc(8);
    cdi = 1'b0;
    cyc(8);
    chk(cds, 1'b0);
    xf(1, 8'h76, 8'h80, 0);
    cyc(2);
    chk(cds, 1'b0);
    cdi = 1'b1;
    cyc(8);
    cdi = 1'b0;
    cyc(8);
    chk(cds, 1'b1);
    xf(1, 8'h78, 8'h80, 0);
    cyc(3);
    chk(cds, 1'b0);
    $display("test clock detect done");
    results();
  end
endmodule : tb_fault_report_control

`default_nettype wire
